// ==== psob_consts.svh ====
// constants for the strap source select and bus address block
// assumes inclusion by the package and design files by bare name
//
// Summary of operation
// (R1) stored values replace strap values unless the matching select bit is set
// (R2) select word writes take effect at once; straps sampled at power-on only
// (R3) bit 12 picks stored or strap phase count
// (R4) bit 11 picks stored or strap synchronisation setting
// (R5) bit 9 picks stored or strap compensation choice
// (R6) bit 8 picks stored or strap bus address
// (R7) bit 5 picks stored or strap phase offset setting
// (R8) bit 3 picks stored or strap soft start time
// (R9) bit 2 picks source of both overcurrent trip and alert levels
// (R10) bit 1 picks stored or strap switching rate
// (R11) bit 0 picks source of output target, feedback ratio, upper and lower limits
// (R12) host writes zero to bits 15:13 and 7:6; bits 10 and 4 free
// (R13) address register written by byte write and read by byte read
// (R14) new address answers from the next transaction, no restore needed; a write landing in the load cycle is dropped, the load wins
// (R15) address in bits 6:0; bit 7 reads zero; reset from stored or strap
// (R16) reserved addresses 0x0C, 0x28, 0x37, 0x61 are refused
// (R17) refused write keeps old address and flags invalid data
`ifndef PSOB_CONSTS_SVH
`define PSOB_CONSTS_SVH
`define PSOB_CMD_SELECT 8'hEE
`define PSOB_CMD_ADDR 8'hEF
`define PSOB_BIT_PHASE 12
`define PSOB_BIT_SYNC 11
`define PSOB_BIT_COMP 9
`define PSOB_BIT_ADDR 8
`define PSOB_BIT_OFFSET 5
`define PSOB_BIT_SOFT 3
`define PSOB_BIT_OC 2
`define PSOB_BIT_RATE 1
`define PSOB_BIT_OUT 0
`define PSOB_RSV_A 7'h0C
`define PSOB_RSV_B 7'h28
`define PSOB_RSV_C 7'h37
`define PSOB_RSV_D 7'h61
`define PSOB_SEL_RESET 16'h0000
`define PSOB_ADDR_RESET 7'h00
`define PSOB_SET_W 16
`endif

// ==== psob_pkg.sv ====
// types for the strap source select and bus address block
// assumes the constants header is on the include path
`include "psob_consts.svh"
package psob_pkg;
    // one group of settings, one word per setting except the seven bit bus address
    typedef struct packed {
        logic [`PSOB_SET_W-1:0] phase_count;
        logic [`PSOB_SET_W-1:0] sync_setting;
        logic [`PSOB_SET_W-1:0] comp_choice;
        logic [`PSOB_SET_W-1:0] phase_offset_setting;
        logic [`PSOB_SET_W-1:0] soft_start_time;
        logic [`PSOB_SET_W-1:0] overcurrent_trip_level;
        logic [`PSOB_SET_W-1:0] overcurrent_alert_level;
        logic [`PSOB_SET_W-1:0] switch_rate;
        logic [`PSOB_SET_W-1:0] output_target_level;
        logic [`PSOB_SET_W-1:0] output_feedback_ratio;
        logic [`PSOB_SET_W-1:0] output_upper_limit;
        logic [`PSOB_SET_W-1:0] output_lower_limit;
        logic [6:0] bus_addr;
    } psob_settings_t;
    // one register access from the command decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] cmd;
        logic [15:0] data;
    } psob_access_t;
    // load sequencer states
    typedef enum logic [2:0] {
        PSOB_IDLE = 3'b001,
        PSOB_LOAD = 3'b010,
        PSOB_DONE = 3'b100
    } psob_state_t;
endpackage

// ==== psob_addr_check.sv ====
// reserved bus address filter
// assumes a seven bit candidate address, purely combinational
`timescale 1ns/1ns
`default_nettype none
`include "psob_consts.svh"
module psob_addr_check (
    // candidate
    input wire logic [6:0] addr_i,
    // verdict
    output logic reserved_o
);
    // compare against the four reserved values
    assign reserved_o = (addr_i == `PSOB_RSV_A) || (addr_i == `PSOB_RSV_B) ||
                        (addr_i == `PSOB_RSV_C) || (addr_i == `PSOB_RSV_D); // [R16]
endmodule
`default_nettype wire

// ==== psob_top.sv ====
// strap source selection and bus address register
// assumes a command decoder delivers one-cycle read/write strobes with command code
// and that strap and stored values are stable while load_i or restore_i is pulsed
`timescale 1ns/1ns
`default_nettype none
`include "psob_consts.svh"
module psob_top (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // register access
    input wire psob_pkg::psob_access_t acc_i,
    // load requests
    input wire logic load_i,
    input wire logic restore_i,
    // value sources
    input wire psob_pkg::psob_settings_t strap_i,
    input wire psob_pkg::psob_settings_t stored_i,
    input wire logic [15:0] stored_select_i,
    // results
    output psob_pkg::psob_settings_t active_o,
    output logic [15:0] rd_data_o,
    output logic rd_valid_o,
    output logic invalid_data_o,
    output logic [6:0] bus_addr_o,
    output logic load_done_o
);
    import psob_pkg::*;

    psob_state_t state_reg;
    logic [15:0] select_reg;
    psob_settings_t strap_reg;
    psob_settings_t active_reg;
    logic [15:0] rd_data_reg;
    logic rd_valid_reg;
    logic invalid_reg;
    logic done_reg;
    logic por_pending_reg;
    logic addr_reserved;
    logic restore_pending_reg;
    psob_settings_t load_next;

    // reserved address filter for written bytes
    psob_addr_check u_chk (
        .addr_i(acc_i.data[6:0]),
        .reserved_o(addr_reserved)
    );

    // per-setting source choice from the select word
    always_comb begin
        load_next = stored_i; // [R1]
        if (select_reg[`PSOB_BIT_PHASE]) begin
            load_next.phase_count = strap_reg.phase_count; // [R3]
        end
        if (select_reg[`PSOB_BIT_SYNC]) begin
            load_next.sync_setting = strap_reg.sync_setting; // [R4]
        end
        if (select_reg[`PSOB_BIT_COMP]) begin
            load_next.comp_choice = strap_reg.comp_choice; // [R5]
        end
        if (select_reg[`PSOB_BIT_ADDR]) begin
            load_next.bus_addr = strap_reg.bus_addr; // [R6]
        end
        if (select_reg[`PSOB_BIT_OFFSET]) begin
            load_next.phase_offset_setting = strap_reg.phase_offset_setting; // [R7]
        end
        if (select_reg[`PSOB_BIT_SOFT]) begin
            load_next.soft_start_time = strap_reg.soft_start_time; // [R8]
        end
        if (select_reg[`PSOB_BIT_OC]) begin
            load_next.overcurrent_trip_level = strap_reg.overcurrent_trip_level; // [R9]
            load_next.overcurrent_alert_level = strap_reg.overcurrent_alert_level;
        end
        if (select_reg[`PSOB_BIT_RATE]) begin
            load_next.switch_rate = strap_reg.switch_rate; // [R10]
        end
        if (select_reg[`PSOB_BIT_OUT]) begin
            load_next.output_target_level = strap_reg.output_target_level; // [R11]
            load_next.output_feedback_ratio = strap_reg.output_feedback_ratio;
            load_next.output_upper_limit = strap_reg.output_upper_limit;
            load_next.output_lower_limit = strap_reg.output_lower_limit;
        end
    end

    // power-on marker: first load after reset samples the straps
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            por_pending_reg <= 1'b1;
        end else if (state_reg == PSOB_LOAD) begin
            por_pending_reg <= 1'b0;
        end
    end

    // strap capture only at power-on load
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            strap_reg <= '0;
        end else if (state_reg == PSOB_IDLE && por_pending_reg && load_i) begin
            strap_reg <= strap_i; // [R2]
        end
    end

    // taken request marker, high while the sequencer sits in load
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            restore_pending_reg <= 1'b0;
        end else begin
            restore_pending_reg <= (state_reg == PSOB_IDLE) &&
                ((load_i && por_pending_reg) || (restore_i && !por_pending_reg));
        end
    end

    // load sequencer: capture, then apply one cycle later
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= PSOB_IDLE;
        end else begin
            case (state_reg)
                PSOB_IDLE: begin
                    if ((load_i && por_pending_reg) || (restore_i && !por_pending_reg)) begin
                        state_reg <= PSOB_LOAD;
                    end
                end
                PSOB_LOAD: begin
                    state_reg <= PSOB_DONE;
                end
                PSOB_DONE: begin
                    state_reg <= PSOB_IDLE;
                end
                default: begin
                    state_reg <= PSOB_IDLE;
                end
            endcase
        end
    end

    // select word: stored copy at load, host writes on the fly
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            select_reg <= `PSOB_SEL_RESET;
        end else if (acc_i.wr && acc_i.cmd == `PSOB_CMD_SELECT) begin
            select_reg <= acc_i.data; // [R2]
        end else if (state_reg == PSOB_IDLE && load_i && por_pending_reg) begin
            select_reg <= stored_select_i;
        end
    end

    // active settings and live bus address
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            active_reg <= '0;
        end else if (state_reg == PSOB_LOAD) begin
            active_reg <= load_next; // [R1]
        end else if (acc_i.wr && acc_i.cmd == `PSOB_CMD_ADDR && !addr_reserved) begin
            active_reg.bus_addr <= acc_i.data[6:0]; // [R13] [R14]
        end
    end

    // invalid data flag for refused address writes, one cycle
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            invalid_reg <= 1'b0;
        end else begin
            invalid_reg <= acc_i.wr && acc_i.cmd == `PSOB_CMD_ADDR && addr_reserved; // [R17]
        end
    end

    // read path: word for the select, byte with bit 7 zero for the address
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_data_reg <= 16'h0000;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= acc_i.rd;
            if (acc_i.rd && acc_i.cmd == `PSOB_CMD_SELECT) begin
                rd_data_reg <= select_reg;
            end else if (acc_i.rd && acc_i.cmd == `PSOB_CMD_ADDR) begin
                rd_data_reg <= {9'h000, active_reg.bus_addr}; // [R15]
            end else begin
                rd_data_reg <= 16'h0000;
            end
        end
    end

    // load completion pulse
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= (state_reg == PSOB_LOAD);
        end
    end

    assign active_o = active_reg;
    assign bus_addr_o = active_reg.bus_addr;
    assign rd_data_o = rd_data_reg;
    assign rd_valid_o = rd_valid_reg;
    assign invalid_data_o = invalid_reg;
    assign load_done_o = done_reg;

    // reserved write leaves the address unchanged
    chk_reserved_keep: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R16]
        (acc_i.wr && acc_i.cmd == `PSOB_CMD_ADDR && addr_reserved && state_reg != PSOB_LOAD)
        |=> (bus_addr_o == $past(bus_addr_o)) && invalid_data_o)
        else $error("reserved address accepted");
    // valid write answers on the next cycle
    chk_addr_update: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R14]
        (acc_i.wr && acc_i.cmd == `PSOB_CMD_ADDR && !addr_reserved && state_reg != PSOB_LOAD)
        |=> bus_addr_o == $past(acc_i.data[6:0]))
        else $error("address not updated");
    // invalid flag raised only after a refused write
    chk_invalid_flag: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R17]
        invalid_data_o |-> $past(addr_reserved) && $past(acc_i.wr))
        else $error("spurious invalid flag");
    // select written at once
    chk_select_write: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R2]
        (acc_i.wr && acc_i.cmd == `PSOB_CMD_SELECT) |=> select_reg == $past(acc_i.data))
        else $error("select write lost");
    // straps frozen after power-on
    chk_strap_frozen: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R2]
        !por_pending_reg |=> $stable(strap_reg))
        else $error("straps resampled");
    // address read has bit 7 clear
    chk_addr_read: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R15]
        (acc_i.rd && acc_i.cmd == `PSOB_CMD_ADDR) |=> rd_valid_o && rd_data_o[15:7] == 9'h000)
        else $error("address read high bits");
    // load picks the strap address when bit 8 set
    chk_addr_source: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R6]
        (state_reg == PSOB_LOAD && select_reg[`PSOB_BIT_ADDR]) |=> bus_addr_o == $past(strap_reg.bus_addr))
        else $error("address source wrong");
    // load picks the stored rate when bit 1 clear
    chk_rate_source: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R10]
        (state_reg == PSOB_LOAD && !select_reg[`PSOB_BIT_RATE]) ##1 1'b1
        |-> active_o.switch_rate == $past(stored_i.switch_rate))
        else $error("rate source wrong");
    // overcurrent pair moves together
    chk_oc_pair: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R9]
        (state_reg == PSOB_LOAD && select_reg[`PSOB_BIT_OC]) |=>
        active_o.overcurrent_trip_level == $past(strap_reg.overcurrent_trip_level) &&
        active_o.overcurrent_alert_level == $past(strap_reg.overcurrent_alert_level))
        else $error("overcurrent source wrong");
    // completion follows a load by two cycles
    chk_load_done: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R1]
        (state_reg == PSOB_IDLE && load_i && por_pending_reg) |-> ##2 load_done_o)
        else $error("load did not complete");

    // sync setting from the strap when bit 11 set
    chk_sync_strap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R4]
        (state_reg == PSOB_LOAD && select_reg[`PSOB_BIT_SYNC]) |=>
        active_o.sync_setting == $past(strap_reg.sync_setting))
        else $error("sync source wrong");
    // compensation from the strap when bit 9 set
    chk_comp_strap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R5]
        (state_reg == PSOB_LOAD && select_reg[`PSOB_BIT_COMP]) |=>
        active_o.comp_choice == $past(strap_reg.comp_choice))
        else $error("compensation source wrong");
    // phase count from the strap when bit 12 set
    chk_phase_strap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R3]
        (state_reg == PSOB_LOAD && select_reg[`PSOB_BIT_PHASE]) |=>
        active_o.phase_count == $past(strap_reg.phase_count))
        else $error("phase count source wrong");
    // stored address when bit 8 clear
    chk_addr_stored: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R6]
        (state_reg == PSOB_LOAD && !select_reg[`PSOB_BIT_ADDR]) |=> bus_addr_o == $past(stored_i.bus_addr))
        else $error("stored address not taken");
    // phase offset from the strap when bit 5 set
    chk_offset_strap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R7]
        (state_reg == PSOB_LOAD && select_reg[`PSOB_BIT_OFFSET]) |=>
        active_o.phase_offset_setting == $past(strap_reg.phase_offset_setting))
        else $error("offset source wrong");
    // soft start from the strap when bit 3 set
    chk_soft_strap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R8]
        (state_reg == PSOB_LOAD && select_reg[`PSOB_BIT_SOFT]) |=>
        active_o.soft_start_time == $past(strap_reg.soft_start_time))
        else $error("soft start source wrong");
    // overcurrent pair stored together when bit 2 clear
    chk_oc_stored: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R9]
        (state_reg == PSOB_LOAD && !select_reg[`PSOB_BIT_OC]) |=>
        active_o.overcurrent_trip_level == $past(stored_i.overcurrent_trip_level) &&
        active_o.overcurrent_alert_level == $past(stored_i.overcurrent_alert_level))
        else $error("overcurrent stored pair wrong");
    // switching rate from the strap when bit 1 set
    chk_rate_strap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R10]
        (state_reg == PSOB_LOAD && select_reg[`PSOB_BIT_RATE]) |=>
        active_o.switch_rate == $past(strap_reg.switch_rate))
        else $error("rate strap not taken");
    // output group from the strap when bit 0 set
    chk_out_strap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R11]
        (state_reg == PSOB_LOAD && select_reg[`PSOB_BIT_OUT]) |=>
        active_o.output_target_level == $past(strap_reg.output_target_level) &&
        active_o.output_feedback_ratio == $past(strap_reg.output_feedback_ratio) &&
        active_o.output_upper_limit == $past(strap_reg.output_upper_limit) &&
        active_o.output_lower_limit == $past(strap_reg.output_lower_limit))
        else $error("output group source wrong");
    // output target stored when bit 0 clear
    chk_out_stored: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R11]
        (state_reg == PSOB_LOAD && !select_reg[`PSOB_BIT_OUT]) |=>
        active_o.output_target_level == $past(stored_i.output_target_level))
        else $error("output stored value wrong");

    // select moves only on a write or the power-on load
    chk_select_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R2]
        !(acc_i.wr && acc_i.cmd == `PSOB_CMD_SELECT) && !(state_reg == PSOB_IDLE && load_i && por_pending_reg)
        |=> $stable(select_reg))
        else $error("select changed unasked");
    // address moves only on a write or a load
    chk_addr_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R14]
        (!(acc_i.wr && acc_i.cmd == `PSOB_CMD_ADDR) && state_reg != PSOB_LOAD) |=> $stable(bus_addr_o))
        else $error("address changed unasked");
    // select read returns the live word
    chk_select_read: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R2]
        (acc_i.rd && acc_i.cmd == `PSOB_CMD_SELECT) |=> rd_data_o == $past(select_reg))
        else $error("select read wrong");
    // address read returns the live address
    chk_addr_readback: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R13]
        (acc_i.rd && acc_i.cmd == `PSOB_CMD_ADDR) |=> rd_data_o[6:0] == $past(bus_addr_o))
        else $error("address read wrong");
    // every read answered next cycle
    chk_read_valid: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R13]
        acc_i.rd |=> rd_valid_o)
        else $error("read not answered");
    // no answer without a read
    chk_read_quiet: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R13]
        !acc_i.rd |=> !rd_valid_o)
        else $error("spurious read answer");

    // later load requests never resample
    chk_no_reload: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R2]
        (state_reg == PSOB_IDLE && !por_pending_reg && !restore_i) |=> state_reg == PSOB_IDLE)
        else $error("second load accepted");
    // restore before the power-on load is ignored
    chk_early_restore: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R1]
        (state_reg == PSOB_IDLE && por_pending_reg && !load_i) |=> state_reg == PSOB_IDLE && por_pending_reg)
        else $error("early restore accepted");
    // power-on marker drops after the first load
    chk_por_clear: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R2]
        state_reg == PSOB_LOAD |=> !por_pending_reg)
        else $error("power-on marker stuck");
    // taken marker and sequencer agree
    chk_load_entry: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R1]
        restore_pending_reg == (state_reg == PSOB_LOAD))
        else $error("load entry mismatch");
    // completion lasts one cycle
    chk_done_pulse: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R1]
        load_done_o |=> !load_done_o)
        else $error("done pulse too long");
    // accepted address raises no flag
    chk_valid_quiet: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R17]
        (acc_i.wr && acc_i.cmd == `PSOB_CMD_ADDR && !addr_reserved) |=> !invalid_data_o)
        else $error("valid address flagged");
    // straps captured at the power-on load
    chk_strap_capture: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R2]
        (state_reg == PSOB_IDLE && por_pending_reg && load_i) |=> strap_reg == $past(strap_i))
        else $error("straps not captured");
endmodule
`default_nettype wire

// ==== psob_host_model.sv ====
// host controller model issuing word and byte register transactions
// assumes registered read answers one cycle after the read strobe is taken
`timescale 1ns/1ns
`default_nettype none
module psob_host_model (
    // clock
    input wire logic ref_clk_i,
    // answers
    input wire logic [15:0] rd_data_i,
    input wire logic rd_valid_i,
    // requests
    output var psob_pkg::psob_access_t acc_o
);
    import psob_pkg::*;
    initial acc_o = '0;
    // word write to select, byte write to address; strobe held one edge
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge ref_clk_i);
        acc_o <= '{wr: 1'b1, rd: 1'b0, cmd: c, data: (c == 8'hEE) ? (d & 16'h1F3F) : {8'h00, d[7:0]}};
        @(posedge ref_clk_i);
        acc_o <= '0;
    endtask
    // read; answer taken once the registered outputs have settled
    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
        @(posedge ref_clk_i);
        acc_o <= '{wr: 1'b0, rd: 1'b1, cmd: c, data: 16'h0000};
        @(posedge ref_clk_i);
        acc_o <= '0;
        #1;
        ok = rd_valid_i;
        d = rd_data_i;
    endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for strap source selection and bus address register
// assumes the host model file and the design package are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
    import psob_pkg::*;
    logic ref_clk_i, nrst_i, load_i, restore_i, rd_valid_o, invalid_data_o, load_done_o, ok;
    logic [15:0] stored_select_i, rd_data_o, rdat;
    logic [6:0] bus_addr_o;
    psob_access_t acc_i;
    psob_settings_t strap_i, stored_i, active_o, ps;
    int num_errors = 0;
    int compares = 0;
    psob_top uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .acc_i(acc_i), .load_i(load_i),
        .restore_i(restore_i), .strap_i(strap_i), .stored_i(stored_i), .stored_select_i(stored_select_i),
        .active_o(active_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .invalid_data_o(invalid_data_o), .bus_addr_o(bus_addr_o), .load_done_o(load_done_o));
    psob_host_model host (.ref_clk_i(ref_clk_i), .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o), .acc_o(acc_i));
    // clock
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    task automatic check(input logic [255:0] seen, input logic [255:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // expected applied settings from a select word and the power-on straps
    function automatic psob_settings_t expect_set(input logic [15:0] s);
        psob_settings_t e;
        e = stored_i;
        if (s[12]) e.phase_count = ps.phase_count;
        if (s[11]) e.sync_setting = ps.sync_setting;
        if (s[9]) e.comp_choice = ps.comp_choice;
        if (s[8]) e.bus_addr = ps.bus_addr;
        if (s[5]) e.phase_offset_setting = ps.phase_offset_setting;
        if (s[3]) e.soft_start_time = ps.soft_start_time;
        if (s[2]) begin
            e.overcurrent_trip_level = ps.overcurrent_trip_level;
            e.overcurrent_alert_level = ps.overcurrent_alert_level;
        end
        if (s[1]) e.switch_rate = ps.switch_rate;
        if (s[0]) begin
            e.output_target_level = ps.output_target_level;
            e.output_feedback_ratio = ps.output_feedback_ratio;
            e.output_upper_limit = ps.output_upper_limit;
            e.output_lower_limit = ps.output_lower_limit;
        end
        return e;
    endfunction
    // load or restore pulse, done pulse looked at two cycles later
    task automatic request(input logic is_restore, input logic exp_done);
        @(posedge ref_clk_i);
        if (is_restore) restore_i <= 1'b1;
        else load_i <= 1'b1;
        @(posedge ref_clk_i);
        restore_i <= 1'b0;
        load_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        check(load_done_o, exp_done, "load done");
    endtask
    task automatic test_reset;
        check(active_o, '0, "reset settings");
        check(bus_addr_o, 7'h00, "reset address");
        host.rd(8'hEE, rdat, ok);
        check({ok, rdat}, 17'h10000, "reset select");
        $display("test reset done");
    endtask
    task automatic test_power_on;
        request(1'b0, 1'b1);
        check(active_o, expect_set(16'h1B2F), "power-on settings");
        strap_i <= ~ps;
        request(1'b0, 1'b0);
        check(active_o, expect_set(16'h1B2F), "second load ignored");
        $display("test power_on done");
    endtask
    task automatic test_select;
        logic [15:0] sels [11] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0020,
            16'h0100, 16'h0200, 16'h0800, 16'h1000, 16'h0410};
        psob_settings_t e;
        foreach (sels[i]) begin
            host.wr(8'hEE, sels[i]);
            host.rd(8'hEE, rdat, ok);
            check({ok, rdat}, {1'b1, sels[i]}, "select readback");
            request(1'b1, 1'b1);
            e = expect_set(sels[i]);
            check(active_o, e, "restored settings");
            check(bus_addr_o, e.bus_addr, "restored address");
        end
        $display("test select done");
    endtask
    task automatic test_addr;
        logic [7:0] rsv [4] = '{8'h0C, 8'h28, 8'h37, 8'h61};
        host.wr(8'hEF, 16'h0022);
        #1;
        check({invalid_data_o, bus_addr_o}, 8'h22, "new address");
        host.rd(8'hEF, rdat, ok);
        check({ok, rdat}, 17'h10022, "address readback");
        host.wr(8'hEF, 16'h00A5);
        host.rd(8'hEF, rdat, ok);
        check({ok, rdat}, 17'h10025, "top bit zero");
        foreach (rsv[i]) begin
            host.wr(8'hEF, {8'h00, rsv[i]});
            #1;
            check({invalid_data_o, bus_addr_o}, 8'hA5, "reserved refused");
        end
        $display("test addr done");
    endtask
    // watchdog
    initial begin
        #100000;
        num_errors++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end
    initial begin
        nrst_i = 1'b0;
        load_i = 1'b0;
        restore_i = 1'b0;
        strap_i = {{12{16'hA5A5}}, 7'h11};
        stored_i = {{12{16'h5A5A}}, 7'h33};
        stored_select_i = 16'h1B2F;
        ps = strap_i;
        repeat (8) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        @(posedge ref_clk_i);
        #1;
        test_reset();
        test_power_on();
        test_select();
        test_addr();
        finish_test();
    end
endmodule
`default_nettype wire
